// [rtl/scpc_div.sv]
// Step divider producing a one-cycle tick every ratio steps
module scpc_div (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Step input and ratio
  input wire logic step_i,
  input wire logic [7:0] ratio_i,
  // Tick out
  output logic tick_o
);

  logic [7:0] cnt_q;

  // Count steps, wrap and tick at ratio
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      if (step_i) begin
        if (cnt_q >= ratio_i - 8'h01) begin
          cnt_q <= 8'h00;
          tick_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 8'h01;
          tick_o <= 1'b0;
        end
      end else begin
        tick_o <= 1'b0;
      end
    end
  end

endmodule : scpc_div

// [rtl/scpc_pkg.sv]
// Constants and carrier types for the system clock and power control block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package scpc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CLKCTRL = 8'h08;
  localparam logic [7:0] OFF_PM = 8'h0c;
  localparam logic [7:0] OFF_PCLKDIV = 8'h18;
  localparam logic [7:0] OFF_PCLKDIS0 = 8'h24;

  // Clock control field positions
  localparam int CK_DNM = 30;
  localparam int CK_RDY_INRO = 29;
  localparam int CK_RDY_ERTCO = 25;
  localparam int CK_BAUD_VS = 21;
  localparam int CK_BAUD_EN = 20;
  localparam int CK_IPO_EN = 19;
  localparam int CK_ISO_EN = 18;
  localparam int CK_ERTCO_EN = 17;
  localparam int CK_SYS_RDY = 13;
  localparam int CK_SEL = 9;
  localparam int CK_DIV = 6;

  // Power management field positions
  localparam int PM_BAUD_PD = 17;
  localparam int PM_PRIMARY_OSC_LOWPOWER_OFF = 16;
  localparam int PM_SECONDARY_OSC_LOWPOWER_OFF = 15;
  localparam int PM_DNM = 10;
  localparam int PM_AINC_WE = 9;
  localparam int PM_WUT_WE = 7;
  localparam int PM_RTC_WE = 5;
  localparam int PM_GPIO_WE = 4;
  localparam int PM_MODE = 0;

  // Peripheral divisor field positions
  localparam int PD_CNN_SEL = 17;
  localparam int PD_CNN_DIV = 14;
  localparam int PD_ADC_FRQ = 10;

  // Reset values
  localparam logic [1:0] CK_DNM_RST = 2'h1;
  localparam logic [5:0] CK_LOW_RST = 6'h08;
  localparam logic [4:0] PM_DNM_RST = 5'h1c;
  localparam logic [31:0] PCD_RST = 32'hffffffff;

  // Writable bits of the clock-disable register
  localparam logic [31:0] PCD_WMASK = 32'hf287a663;

  // Source selector codes
  localparam logic [2:0] SRC_ISO = 3'h0;
  localparam logic [2:0] SRC_INRO = 3'h3;
  localparam logic [2:0] SRC_IPO = 3'h4;
  localparam logic [2:0] SRC_IBRO = 3'h5;
  localparam logic [2:0] SRC_ERTCO = 3'h6;
  localparam logic [2:0] SRC_EXT = 3'h7;

  // Operating modes
  localparam logic [3:0] MODE_ACTIVE = 4'h0;
  localparam logic [3:0] MODE_SLEEP = 4'h1;
  localparam logic [3:0] MODE_BACKUP = 4'h4;
  localparam logic [3:0] MODE_LPM = 4'h8;

  // Handover settle time in clock cycles and least converter divisor
  localparam logic [1:0] HAND_CYC = 2'h2;
  localparam logic [3:0] ADC_MIN_DIV = 4'h2;

  // Switchover states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_HAND = 3'b100
  } scpc_sw_e;

  // One bit per oscillator
  typedef struct packed {
    logic inro;
    logic ibro;
    logic ipo;
    logic iso;
    logic ertco;
  } scpc_osc_s;

  // Wake event sources
  typedef struct packed {
    logic aincomp;
    logic wut;
    logic rtc;
    logic gpio;
  } scpc_wake_s;

endpackage : scpc_pkg

// [rtl/scpc_top.sv]
// System clock and power control register bank with switchover logic
module scpc_top (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Oscillator status and control
  input wire scpc_pkg::scpc_osc_s osc_stable_i,
  input wire logic rtc_en_i,
  output scpc_pkg::scpc_osc_s osc_run_o,
  output logic baud_supply_sel_o,
  output logic [2:0] active_src_o,
  // Derived clock enables
  output logic sysclk_tick_o,
  output logic cnn_clk_sel_o,
  output logic cnn_tick_o,
  output logic adc_tick_o,
  // Power modes and wake
  input wire scpc_pkg::scpc_wake_s wake_evt_i,
  output logic [3:0] mode_o,
  output logic wake_o,
  // Peripheral clock gates
  output logic [31:0] periph_clk_dis_o
);

  //----------------------------------------------------------------------------
  // Storage
  //----------------------------------------------------------------------------
  logic [1:0] ck_dnm_q;
  logic baud_vs_q;
  logic ipo_en_q;
  logic iso_en_q;
  logic ertco_en_q;
  logic [2:0] sel_q;
  logic [2:0] div_q;
  logic rdy_q;
  logic baud_pd_q;
  logic primary_osc_lowpower_off_q;
  logic secondary_osc_lowpower_off_q;
  logic [4:0] pm_dnm_q;
  scpc_pkg::scpc_wake_s wen_q;
  logic [3:0] mode_q;
  logic cnn_sel_q;
  logic [2:0] cnn_div_q;
  logic [3:0] adc_frq_q;
  logic [31:0] pcd_q;
  scpc_pkg::scpc_osc_s ordy_q;
  scpc_pkg::scpc_sw_e st_q;
  logic [1:0] hcnt_q;

  logic [31:0] ck_img;
  logic [31:0] pm_img;
  logic [31:0] pd_img;
  logic [31:0] ck_wr;
  logic [31:0] pm_wr;
  logic [31:0] pd_wr;
  logic [31:0] pcd_wr;
  logic acc;
  logic wr_ck;
  logic wr_pm;
  logic wr_pd;
  logic wr_pcd;
  logic sel_chg;
  logic tgt_rdy;
  logic low_power_state;
  logic sleepish;
  logic wake_hit;
  logic sys_tick;
  logic [7:0] adc_ratio;

  // Byte-lane merge of write data over an old image
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  //----------------------------------------------------------------------------
  // Read images
  //----------------------------------------------------------------------------
  // Clock control image
  always_comb begin
    ck_img = 32'h00000000;
    ck_img[scpc_pkg::CK_DNM +: 2] = ck_dnm_q;
    ck_img[scpc_pkg::CK_RDY_ERTCO +: 5] = ordy_q;
    ck_img[scpc_pkg::CK_BAUD_VS] = baud_vs_q;
    ck_img[scpc_pkg::CK_BAUD_EN] = 1'b1;
    ck_img[scpc_pkg::CK_IPO_EN] = ipo_en_q;
    ck_img[scpc_pkg::CK_ISO_EN] = iso_en_q;
    ck_img[scpc_pkg::CK_ERTCO_EN] = ertco_en_q;
    ck_img[scpc_pkg::CK_SYS_RDY] = rdy_q;
    ck_img[scpc_pkg::CK_SEL +: 3] = sel_q;
    ck_img[scpc_pkg::CK_DIV +: 3] = div_q;
    ck_img[5:0] = scpc_pkg::CK_LOW_RST;
  end

  // Power management image
  always_comb begin
    pm_img = 32'h00000000;
    pm_img[scpc_pkg::PM_BAUD_PD] = baud_pd_q;
    pm_img[scpc_pkg::PM_PRIMARY_OSC_LOWPOWER_OFF] = primary_osc_lowpower_off_q;
    pm_img[scpc_pkg::PM_SECONDARY_OSC_LOWPOWER_OFF] = secondary_osc_lowpower_off_q;
    pm_img[scpc_pkg::PM_DNM +: 5] = pm_dnm_q;
    pm_img[scpc_pkg::PM_AINC_WE] = wen_q.aincomp;
    pm_img[scpc_pkg::PM_WUT_WE] = wen_q.wut;
    pm_img[scpc_pkg::PM_RTC_WE] = wen_q.rtc;
    pm_img[scpc_pkg::PM_GPIO_WE] = wen_q.gpio;
    pm_img[scpc_pkg::PM_MODE +: 4] = mode_q;
  end

  // Peripheral divisor image
  always_comb begin
    pd_img = 32'h00000000;
    pd_img[scpc_pkg::PD_CNN_SEL] = cnn_sel_q;
    pd_img[scpc_pkg::PD_CNN_DIV +: 3] = cnn_div_q;
    pd_img[scpc_pkg::PD_ADC_FRQ +: 4] = adc_frq_q;
  end

  //----------------------------------------------------------------------------
  // Bus decode
  //----------------------------------------------------------------------------
  // Strobes for a fresh request
  assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ck_wr = merge(ck_img, wb_dat_i, wb_sel_i);
  assign pm_wr = merge(pm_img, wb_dat_i, wb_sel_i);
  assign pd_wr = merge(pd_img, wb_dat_i, wb_sel_i);
  assign pcd_wr = merge(pcd_q, wb_dat_i, wb_sel_i);

  // Address decode of write strobes
  always_comb begin
    wr_ck = 1'b0;
    wr_pm = 1'b0;
    wr_pd = 1'b0;
    wr_pcd = 1'b0;
    if (acc && wb_we_i) begin
      if (wb_adr_i == scpc_pkg::OFF_CLKCTRL) begin
        wr_ck = 1'b1;
      end else if (wb_adr_i == scpc_pkg::OFF_PM) begin
        wr_pm = 1'b1;
      end else if (wb_adr_i == scpc_pkg::OFF_PCLKDIV) begin
        wr_pd = 1'b1;
      end else if (wb_adr_i == scpc_pkg::OFF_PCLKDIS0) begin
        wr_pcd = 1'b1;
      end
    end
  end

  assign sel_chg = wr_ck && (ck_wr[scpc_pkg::CK_SEL +: 3] != sel_q);

  // Acknowledge and read data, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= acc;
      if (acc && !wb_we_i) begin
        if (wb_adr_i == scpc_pkg::OFF_CLKCTRL) begin
          wb_dat_o <= ck_img;
        end else if (wb_adr_i == scpc_pkg::OFF_PM) begin
          wb_dat_o <= pm_img;
        end else if (wb_adr_i == scpc_pkg::OFF_PCLKDIV) begin
          wb_dat_o <= pd_img;
        end else if (wb_adr_i == scpc_pkg::OFF_PCLKDIS0) begin
          wb_dat_o <= pcd_q;
        end else begin
          wb_dat_o <= 32'h00000000;
        end
      end
    end
  end

  //----------------------------------------------------------------------------
  // Clock control register
  //----------------------------------------------------------------------------
  // Only system or power-on reset reaches this bank
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ck_dnm_q <= scpc_pkg::CK_DNM_RST;
      baud_vs_q <= 1'b0;
      ipo_en_q <= 1'b0;
      iso_en_q <= 1'b1;
      ertco_en_q <= 1'b0;
      sel_q <= scpc_pkg::SRC_ISO;
      div_q <= 3'h0;
    end else if (ce_i && wr_ck) begin
      ck_dnm_q <= ck_wr[scpc_pkg::CK_DNM +: 2];
      baud_vs_q <= ck_wr[scpc_pkg::CK_BAUD_VS];
      ipo_en_q <= ck_wr[scpc_pkg::CK_IPO_EN];
      iso_en_q <= ck_wr[scpc_pkg::CK_ISO_EN];
      ertco_en_q <= ck_wr[scpc_pkg::CK_ERTCO_EN];
      sel_q <= ck_wr[scpc_pkg::CK_SEL +: 3];
      div_q <= ck_wr[scpc_pkg::CK_DIV +: 3];
    end
  end

  //----------------------------------------------------------------------------
  // Oscillator run and ready
  //----------------------------------------------------------------------------
  assign low_power_state = (mode_q == scpc_pkg::MODE_LPM);

  // Run enables and ready flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_run_o <= '0;
      ordy_q <= '0;
      baud_supply_sel_o <= 1'b0;
    end else if (ce_i) begin
      osc_run_o.inro <= 1'b1;
      osc_run_o.ibro <= ~(low_power_state & baud_pd_q);
      osc_run_o.ipo <= ipo_en_q & ~(low_power_state & primary_osc_lowpower_off_q);
      osc_run_o.iso <= iso_en_q & ~(low_power_state & secondary_osc_lowpower_off_q);
      osc_run_o.ertco <= ertco_en_q | rtc_en_i;
      ordy_q <= osc_run_o & osc_stable_i;
      baud_supply_sel_o <= baud_vs_q;
    end
  end

  // Ready of the chosen target, reserved codes never ready
  always_comb begin
    case (sel_q)
      scpc_pkg::SRC_ISO: tgt_rdy = ordy_q.iso;
      scpc_pkg::SRC_INRO: tgt_rdy = ordy_q.inro;
      scpc_pkg::SRC_IPO: tgt_rdy = ordy_q.ipo;
      scpc_pkg::SRC_IBRO: tgt_rdy = ordy_q.ibro;
      scpc_pkg::SRC_ERTCO: tgt_rdy = ordy_q.ertco;
      scpc_pkg::SRC_EXT: tgt_rdy = 1'b1;
      default: tgt_rdy = 1'b0;
    endcase
  end

  //----------------------------------------------------------------------------
  // Switchover sequencer
  //----------------------------------------------------------------------------
  // Wait for target ready, settle, then hand over
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= scpc_pkg::ST_WAIT;
      hcnt_q <= 2'h0;
      rdy_q <= 1'b0;
      active_src_o <= scpc_pkg::SRC_ISO;
    end else if (ce_i) begin
      if (sel_chg) begin
        st_q <= scpc_pkg::ST_WAIT;
        rdy_q <= 1'b0;
      end else begin
        case (st_q)
          scpc_pkg::ST_WAIT: begin
            hcnt_q <= 2'h0;
            if (tgt_rdy) begin
              st_q <= scpc_pkg::ST_HAND;
            end
          end
          scpc_pkg::ST_HAND: begin
            if (!tgt_rdy) begin
              st_q <= scpc_pkg::ST_WAIT;
            end else if (hcnt_q == scpc_pkg::HAND_CYC - 2'h1) begin
              st_q <= scpc_pkg::ST_IDLE;
              active_src_o <= sel_q;
              rdy_q <= 1'b1;
            end else begin
              hcnt_q <= hcnt_q + 2'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  //----------------------------------------------------------------------------
  // Power management register and wake
  //----------------------------------------------------------------------------
  assign sleepish = (mode_q == scpc_pkg::MODE_SLEEP) || low_power_state
                    || (mode_q == scpc_pkg::MODE_BACKUP);
  assign wake_hit = |(wake_evt_i & wen_q);

  // Field writes, a wake event wins over a same-cycle write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      baud_pd_q <= 1'b1;
      primary_osc_lowpower_off_q <= 1'b1;
      secondary_osc_lowpower_off_q <= 1'b1;
      pm_dnm_q <= scpc_pkg::PM_DNM_RST;
      wen_q <= '0;
      mode_q <= scpc_pkg::MODE_ACTIVE;
      wake_o <= 1'b0;
    end else if (ce_i) begin
      if (wr_pm) begin
        baud_pd_q <= pm_wr[scpc_pkg::PM_BAUD_PD];
        primary_osc_lowpower_off_q <= pm_wr[scpc_pkg::PM_PRIMARY_OSC_LOWPOWER_OFF];
        secondary_osc_lowpower_off_q <= pm_wr[scpc_pkg::PM_SECONDARY_OSC_LOWPOWER_OFF];
        pm_dnm_q <= pm_wr[scpc_pkg::PM_DNM +: 5];
        wen_q.aincomp <= pm_wr[scpc_pkg::PM_AINC_WE];
        wen_q.wut <= pm_wr[scpc_pkg::PM_WUT_WE];
        wen_q.rtc <= pm_wr[scpc_pkg::PM_RTC_WE];
        wen_q.gpio <= pm_wr[scpc_pkg::PM_GPIO_WE];
        mode_q <= pm_wr[scpc_pkg::PM_MODE +: 4];
      end
      wake_o <= sleepish & wake_hit;
      if (sleepish && wake_hit) begin
        mode_q <= scpc_pkg::MODE_ACTIVE;
      end
    end
  end

  always_comb mode_o = mode_q;

  //----------------------------------------------------------------------------
  // Peripheral divisor and gates
  //----------------------------------------------------------------------------
  // Divisor fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnn_sel_q <= 1'b0;
      cnn_div_q <= 3'h0;
      adc_frq_q <= 4'h0;
    end else if (ce_i && wr_pd) begin
      cnn_sel_q <= pd_wr[scpc_pkg::PD_CNN_SEL];
      cnn_div_q <= pd_wr[scpc_pkg::PD_CNN_DIV +: 3];
      adc_frq_q <= pd_wr[scpc_pkg::PD_ADC_FRQ +: 4];
    end
  end

  // Clock-disable bits, reserved bits hold their ones
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pcd_q <= scpc_pkg::PCD_RST;
    end else if (ce_i && wr_pcd) begin
      pcd_q <= (pcd_q & ~scpc_pkg::PCD_WMASK) | (pcd_wr & scpc_pkg::PCD_WMASK);
    end
  end

  always_comb periph_clk_dis_o = pcd_q;
  always_comb cnn_clk_sel_o = cnn_sel_q;

  //----------------------------------------------------------------------------
  // Clock dividers
  //----------------------------------------------------------------------------
  // Reserved converter divisors fall back to the least one
  assign adc_ratio = {4'h0, (adc_frq_q < scpc_pkg::ADC_MIN_DIV) ? scpc_pkg::ADC_MIN_DIV
                                                                 : adc_frq_q};

  // System clock, selected oscillator over a power of two
  scpc_div u_sys (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .step_i(1'b1),
    .ratio_i(8'h01 << div_q),
    .tick_o(sys_tick)
  );

  // Accelerator clock from peripheral clock or secondary oscillator
  scpc_div u_cnn (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .step_i(cnn_sel_q | sys_tick),
    .ratio_i(8'h01 << cnn_div_q),
    .tick_o(cnn_tick_o)
  );

  // Converter clock from peripheral clock
  scpc_div u_adc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .step_i(sys_tick),
    .ratio_i(adc_ratio),
    .tick_o(adc_tick_o)
  );

  always_comb sysclk_tick_o = sys_tick;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  sequence s_sel_write;
    ce_i && sel_chg;
  endsequence

  sequence s_handover;
    ce_i && st_q == scpc_pkg::ST_HAND && tgt_rdy && hcnt_q == scpc_pkg::HAND_CYC - 2'h1;
  endsequence

  chk_sel_clears_rdy: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sel_write |=> !rdy_q) else $error("done flag not cleared on select change");

  chk_rdy_after_hand: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(rdy_q) |-> $past(st_q == scpc_pkg::ST_HAND) && active_src_o == sel_q)
    else $error("done flag rose without handover");

  chk_hand_sets_rdy: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_handover and !sel_chg) |=> rdy_q && st_q == scpc_pkg::ST_IDLE)
    else $error("handover did not finish");

  chk_div_one_gap: assert property (@(posedge clk_i) disable iff (rst_i)
    sys_tick && div_q == 3'h1 && ce_i |=> !sys_tick) else $error("divide by two broken");

  chk_baud_en_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(wb_adr_i == scpc_pkg::OFF_CLKCTRL && !wb_we_i)
    |-> wb_dat_o[scpc_pkg::CK_BAUD_EN]) else $error("baud enable read zero");

  chk_rtc_xtal_run: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (ertco_en_q || rtc_en_i) |=> osc_run_o.ertco) else $error("rtc crystal stopped");

  chk_lpm_ipo_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && low_power_state && primary_osc_lowpower_off_q |=> !osc_run_o.ipo) else $error("primary ran in low power");

  chk_wake_to_active: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_o |-> mode_q == scpc_pkg::MODE_ACTIVE) else $error("wake left mode asleep");

  chk_reset_values: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> iso_en_q && !ipo_en_q && pcd_q == scpc_pkg::PCD_RST)
    else $error("bad reset values");

  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack held two cycles");

endmodule : scpc_top

// [test/scpc_top_bench.sv]
// Self-checking bench for the clock and power control register bank
module scpc_top_bench;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin errors++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

  //----------------------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  scpc_pkg::scpc_osc_s osc_stable_i = '1;
  logic rtc_en_i = 1'b0;
  scpc_pkg::scpc_osc_s osc_run_o;
  logic [2:0] active_src_o;
  logic sysclk_tick_o;
  scpc_pkg::scpc_wake_s wake_evt_i = '0;
  logic [3:0] mode_o;
  logic wake_o;
  logic [31:0] periph_clk_dis_o;
  logic baud_supply_sel_o;
  logic cnn_clk_sel_o;
  logic cnn_tick_o;
  logic adc_tick_o;
  int errors = 0;
  int checks = 0;
  logic [31:0] rd;

  // Clock generator, 25 ns period
  always #12.5 clk_i = ~clk_i;

  scpc_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .osc_stable_i(osc_stable_i), .rtc_en_i(rtc_en_i), .osc_run_o(osc_run_o),
    .baud_supply_sel_o(baud_supply_sel_o), .active_src_o(active_src_o),
    .sysclk_tick_o(sysclk_tick_o), .cnn_clk_sel_o(cnn_clk_sel_o),
    .cnn_tick_o(cnn_tick_o), .adc_tick_o(adc_tick_o),
    .wake_evt_i(wake_evt_i), .mode_o(mode_o), .wake_o(wake_o),
    .periph_clk_dis_o(periph_clk_dis_o)
  );

  //----------------------------------------------------------------------------
  // Bus tasks
  //----------------------------------------------------------------------------
  // One classic cycle; holds the request until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  // Poll clock control until the switchover flag shows the wanted level
  task automatic wait_done(input logic lvl);
    for (int i = 0; i < 30; i++) begin
      wb_xfer(1'b0, 8'h08, 32'h0);
      if (rd[13] === lvl) break;
    end
  endtask : wait_done

  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  // Reset contents of clock control, power management and clock-disable registers, plus an unmapped read
  task automatic t_reset;
    repeat (20) @(posedge clk_i);
    wb_xfer(1'b0, 8'h08, 32'h0);
    `CHK("clkctrl", 32'h74142008, rd)
    `CHK("ready flags", 5'h1a, {rd[29:25]})
    wb_xfer(1'b0, 8'h0c, 32'h0);
    `CHK("pm", 32'h0003f000, rd)
    wb_xfer(1'b0, 8'h24, 32'h0);
    `CHK("clk dis", 32'hffffffff, rd)
    `CHK("clk dis out", 32'hffffffff, periph_clk_dis_o)
    wb_xfer(1'b0, 8'h30, 32'h0);
    `CHK("unmapped", 32'h0, rd)
  endtask : t_reset

  // Switch to the primary source while it is off, then enable it
  task automatic t_switch;
    logic [31:0] base;
    base = 32'h40140008;
    wb_xfer(1'b1, 8'h08, base | (32'h4 << 9));
    wb_xfer(1'b0, 8'h08, 32'h0);
    `CHK("done cleared", 1'b0, rd[13])
    repeat (10) @(posedge clk_i);
    wb_xfer(1'b0, 8'h08, 32'h0);
    `CHK("done held", 1'b0, rd[13])
    `CHK("primary off", 1'b0, rd[27])
    wb_xfer(1'b1, 8'h08, base | (32'h4 << 9) | (32'h1 << 19));
    wait_done(1'b1);
    `CHK("primary rdy", 1'b1, rd[27])
    `CHK("done set", 1'b1, rd[13])
    `CHK("active src", 3'h4, active_src_o)
    wb_xfer(1'b1, 8'h08, base | (32'h1 << 9));
    repeat (10) @(posedge clk_i);
    wb_xfer(1'b0, 8'h08, 32'h0);
    `CHK("reserved src", 1'b0, rd[13])
    wb_xfer(1'b1, 8'h08, base);
    wait_done(1'b1);
    `CHK("back to iso", 3'h0, active_src_o)
  endtask : t_switch

  // Prescaler: ticks counted over a 40-cycle window
  task automatic t_div(input logic [2:0] ex, input int exp_n);
    int n;
    n = 0;
    wb_xfer(1'b1, 8'h08, 32'h40140008 | ({29'h0, ex} << 6));
    repeat (20) @(posedge clk_i);
    repeat (40) begin
      @(posedge clk_i);
      if (sysclk_tick_o === 1'b1) n++;
    end
    `CHK("tick count", exp_n, n)
  endtask : t_div

  // Crystal kept running by either its enable or the RTC enable
  task automatic t_rtc;
    rtc_en_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    `CHK("rtc keeps xtal", 1'b1, osc_run_o.ertco)
    rtc_en_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK("xtal stops", 1'b0, osc_run_o.ertco)
    wb_xfer(1'b1, 8'h08, 32'h40360008);
    repeat (5) @(posedge clk_i);
    `CHK("xtal enabled", 1'b1, osc_run_o.ertco)
    `CHK("supply sel", 1'b1, baud_supply_sel_o)
  endtask : t_rtc

  // Accelerator and converter clock enables over a 36-cycle window
  task automatic t_pdiv(input logic [31:0] val, input int exp_c, input int exp_a);
    int nc;
    int na;
    nc = 0;
    na = 0;
    wb_xfer(1'b1, 8'h18, val);
    wb_xfer(1'b0, 8'h18, 32'h0);
    `CHK("pclkdiv", val, rd)
    `CHK("cnn sel", val[17], cnn_clk_sel_o)
    repeat (10) @(posedge clk_i);
    repeat (36) begin
      @(posedge clk_i);
      if (cnn_tick_o === 1'b1) nc++;
      if (adc_tick_o === 1'b1) na++;
    end
    `CHK("cnn ticks", exp_c, nc)
    `CHK("adc ticks", exp_a, na)
  endtask : t_pdiv

  // Clock-disable bits: only mapped gates clear
  task automatic t_gate;
    wb_xfer(1'b1, 8'h24, 32'h0);
    wb_xfer(1'b0, 8'h24, 32'h0);
    `CHK("gate read", 32'h0d78599c, rd)
    `CHK("gate out", 32'h0d78599c, periph_clk_dis_o)
  endtask : t_gate

  // Sleep, a disabled wake source, then an enabled one
  task automatic t_wake;
    int i;
    wb_xfer(1'b1, 8'h0c, 32'h0003f018);
    `CHK("lpm mode", 4'h8, mode_o)
    repeat (3) @(posedge clk_i);
    `CHK("iso off in lpm", 1'b0, osc_run_o.iso)
    `CHK("baud off in lpm", 1'b0, osc_run_o.ibro)
    wb_xfer(1'b1, 8'h0c, 32'h0003f011);
    `CHK("sleep mode", 4'h1, mode_o)
    wake_evt_i.wut <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("masked wake", 4'h1, mode_o)
    wake_evt_i.wut <= 1'b0;
    wake_evt_i.gpio <= 1'b1;
    for (i = 0; i < 6; i++) begin
      @(posedge clk_i);
      if (wake_o === 1'b1) break;
    end
    `CHK("gpio wake", 1'b1, wake_o)
    wake_evt_i.gpio <= 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK("back active", 4'h0, mode_o)
  endtask : t_wake

  //----------------------------------------------------------------------------
  // Verdict and sequencing
  //----------------------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // Watchdog cut-off well past the expected run
  initial begin
    repeat (6000) @(posedge clk_i);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_switch();
    t_div(3'h2, 10);
    t_div(3'h1, 20);
    t_div(3'h0, 40);
    t_rtc();
    t_pdiv(32'h00024c00, 18, 12);
    t_pdiv(32'h00000000, 36, 18);
    t_gate();
    t_wake();
    close_out();
  end

endmodule : scpc_top_bench
